/* src/dctoi_top.v */
// dual channel torque off interlock with apb register slave
// Functional notes
// - pulses up to 1 ms on either input are ignored.
// - inputs lost removes gate drive so motor gets no torque and coasts.
// - loss raises indication chosen per running state and per stopped state.
// - indication setting never changes torque removal behaviour.
// - running drive stops when either or both inputs are removed.
// - start blocked until both inputs present and all faults reset.
// - loss of only one input lasting past the discrepancy window raises a fault.
// - no restart by itself; fresh start command needed after restoration.
// - separate fault codes for channel a loss and channel b loss.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`include "dctoi_regs.vh"

module dctoi_top #(
   parameter [15:0] P_PULSE_CYC = `DCTOI_PULSE_CYC,
   parameter [23:0] P_DISC_CYC = `DCTOI_DISC_CYC
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_safety_input_a,
   input wire i_safety_input_b,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg o_pready,
   output reg [31:0] o_prdata,
   output reg o_pslverr,
   output reg o_gate_enable,
   output reg o_warning,
   output reg o_fault,
   output reg o_channel_a_loss_fault,
   output reg o_channel_b_loss_fault,
   output reg o_irq
);

   // raw pins packed so the channel loop can index them
   wire [1:0] raw_in;
   wire [1:0] filt_w;

   assign raw_in = {i_safety_input_b, i_safety_input_a};

   // per channel synchroniser and pulse filter
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gen_ch
         reg sync1_reg;
         reg sync2_reg;
         reg filt_reg;
         reg [15:0] cnt_reg;
         // first stage feeds only the second stage
         always @(posedge i_clk) begin
            if (i_rst) begin
               sync1_reg <= 1'b0;
               sync2_reg <= 1'b0;
            end else begin
               sync1_reg <= raw_in[g];
               sync2_reg <= sync1_reg;
            end
         end
         // level must differ for more than the tolerance before it counts
         always @(posedge i_clk) begin
            if (i_rst) begin
               filt_reg <= 1'b0;
               cnt_reg <= 16'h0000;
            end else if (sync2_reg == filt_reg) begin
               cnt_reg <= 16'h0000;
            end else if (cnt_reg >= P_PULSE_CYC) begin
               filt_reg <= sync2_reg;
               cnt_reg <= 16'h0000;
            end else begin
               cnt_reg <= cnt_reg + 16'h0001;
            end
         end
         assign filt_w[g] = filt_reg;
      end
   endgenerate

   // apb access decode
   wire acc_w;
   wire done_w;
   wire wr_w;
   wire rd_done_w;
   wire mapped_w;

   assign acc_w = i_psel & i_penable;
   assign done_w = acc_w & o_pready;
   assign wr_w = done_w & i_pwrite;
   assign rd_done_w = done_w & ~i_pwrite;
   assign mapped_w = (i_paddr == `DCTOI_OFS_CTRL) | (i_paddr == `DCTOI_OFS_CMD) |
                     (i_paddr == `DCTOI_OFS_STATUS) | (i_paddr == `DCTOI_OFS_INT_STAT) |
                     (i_paddr == `DCTOI_OFS_INT_MASK);

   // software visible state and interlock flops
   reg [3:0] ctrl_reg;
   reg [4:0] mask_reg;
   reg [4:0] istat_reg;
   reg [4:0] istat_next;
   reg run_reg;
   reg run_next;
   reg both_prev_reg;
   reg ind_flt_reg;
   reg warn_reg;
   reg a_flt_reg;
   reg b_flt_reg;
   reg [23:0] disc_cnt_reg;

   // decoded strobes, events and fault requests
   wire cmd_wr_w;
   wire cmd_start_w;
   wire cmd_stop_w;
   wire cmd_frst_w;
   wire both_ok_w;
   wire loss_evt_w;
   wire restore_evt_w;
   wire disc_hit_w;
   wire set_a_w;
   wire set_b_w;
   wire any_flt_w;
   wire [1:0] ind_sel_w;
   wire set_ind_flt_w;
   wire set_warn_w;
   wire ind_evt_w;
   wire [7:0] status_w;

   // command strobes only on the completing apb edge
   assign cmd_wr_w = wr_w & (i_paddr == `DCTOI_OFS_CMD);
   assign cmd_start_w = cmd_wr_w & i_pwdata[`DCTOI_CMD_START];
   assign cmd_stop_w = cmd_wr_w & i_pwdata[`DCTOI_CMD_STOP];
   assign cmd_frst_w = cmd_wr_w & i_pwdata[`DCTOI_CMD_FAULT_RST];

   // edges of the both-present level give the loss and restore events
   assign both_ok_w = filt_w[0] & filt_w[1];
   assign loss_evt_w = both_prev_reg & ~both_ok_w;
   assign restore_evt_w = ~both_prev_reg & both_ok_w;

   // one channel lost past the window is a wiring or hardware fault
   assign disc_hit_w = (filt_w[0] != filt_w[1]) & (disc_cnt_reg >= P_DISC_CYC);
   assign set_a_w = disc_hit_w & ~filt_w[0];
   assign set_b_w = disc_hit_w & ~filt_w[1];
   assign any_flt_w = ind_flt_reg | a_flt_reg | b_flt_reg;

   // indication picked by state at the moment of loss
   assign ind_sel_w = run_reg ? ctrl_reg[`DCTOI_CTRL_IND_RUN_LSB +: 2] :
                                ctrl_reg[`DCTOI_CTRL_IND_STOP_LSB +: 2];
   assign set_ind_flt_w = loss_evt_w & (ind_sel_w == `DCTOI_IND_FAULT);
   assign set_warn_w = loss_evt_w & (ind_sel_w == `DCTOI_IND_WARN);
   assign ind_evt_w = loss_evt_w & (ind_sel_w != `DCTOI_IND_NONE);

   // status word as software reads it
   assign status_w = {b_flt_reg, a_flt_reg, ind_flt_reg, warn_reg,
                      o_gate_enable, run_reg, filt_w[1], filt_w[0]};

   // run state: the indication setting has no term here
   always @* begin
      run_next = run_reg;
      if (~both_ok_w | cmd_stop_w) begin
         run_next = 1'b0;
      end else if (cmd_start_w & ~any_flt_w) begin
         // start written while inputs open is dropped, not remembered
         run_next = 1'b1;
      end
   end

   // sticky events; a read clears only bits it returned, so new sets survive
   always @* begin
      istat_next = istat_reg;
      if (rd_done_w && i_paddr == `DCTOI_OFS_INT_STAT) begin
         istat_next = istat_reg & ~o_prdata[`DCTOI_IRQ_W-1:0];
      end
      if (loss_evt_w) begin
         istat_next[`DCTOI_IRQ_LOSS] = 1'b1;
      end
      if (restore_evt_w) begin
         istat_next[`DCTOI_IRQ_RESTORE] = 1'b1;
      end
      if (set_a_w & ~a_flt_reg) begin
         istat_next[`DCTOI_IRQ_A_FLT] = 1'b1;
      end
      if (set_b_w & ~b_flt_reg) begin
         istat_next[`DCTOI_IRQ_B_FLT] = 1'b1;
      end
      if (ind_evt_w) begin
         istat_next[`DCTOI_IRQ_IND] = 1'b1;
      end
   end

   // discrepancy timer runs while the channels disagree
   // it saturates, so a lasting one channel loss keeps its fault request up
   always @(posedge i_clk) begin
      if (i_rst) begin
         disc_cnt_reg <= 24'h000000;
      end else if (filt_w[0] == filt_w[1]) begin
         disc_cnt_reg <= 24'h000000;
      end else if (disc_cnt_reg < P_DISC_CYC) begin
         disc_cnt_reg <= disc_cnt_reg + 24'h000001;
      end
   end

   // interlock state and faults; a fault set beats a reset in the same cycle
   always @(posedge i_clk) begin
      if (i_rst) begin
         run_reg <= 1'b0;
         both_prev_reg <= 1'b0;
         ind_flt_reg <= 1'b0;
         warn_reg <= 1'b0;
         a_flt_reg <= 1'b0;
         b_flt_reg <= 1'b0;
      end else begin
         run_reg <= run_next;
         both_prev_reg <= both_ok_w;
         // reset only takes while both inputs are back
         if (set_ind_flt_w) begin
            ind_flt_reg <= 1'b1;
         end else if (cmd_frst_w & both_ok_w) begin
            ind_flt_reg <= 1'b0;
         end
         if (set_a_w) begin
            a_flt_reg <= 1'b1;
         end else if (cmd_frst_w & both_ok_w) begin
            a_flt_reg <= 1'b0;
         end
         if (set_b_w) begin
            b_flt_reg <= 1'b1;
         end else if (cmd_frst_w & both_ok_w) begin
            b_flt_reg <= 1'b0;
         end
         // warning stands while the inputs stay open
         if (set_warn_w) begin
            warn_reg <= 1'b1;
         end else if (both_ok_w) begin
            warn_reg <= 1'b0;
         end
      end
   end

   // outputs straight from flops; gate drops the cycle after loss is seen
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_gate_enable <= 1'b0;
         o_warning <= 1'b0;
         o_fault <= 1'b0;
         o_channel_a_loss_fault <= 1'b0;
         o_channel_b_loss_fault <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_gate_enable <= run_next & both_ok_w;
         o_warning <= warn_reg;
         o_fault <= any_flt_w;
         o_channel_a_loss_fault <= a_flt_reg;
         o_channel_b_loss_fault <= b_flt_reg;
         o_irq <= |(istat_next & mask_reg);
      end
   end

   // apb slave: one wait state, read data captured in the first access cycle
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
         ctrl_reg <= `DCTOI_CTRL_RST;
         mask_reg <= `DCTOI_INT_MASK_RST;
         istat_reg <= 5'h00;
      end else begin
         istat_reg <= istat_next;
         o_pready <= acc_w & ~o_pready;
         o_pslverr <= acc_w & ~o_pready & ~mapped_w;
         if (acc_w & ~o_pready & ~i_pwrite) begin
            case (i_paddr)
               `DCTOI_OFS_CTRL: begin
                  o_prdata <= {28'h0000000, ctrl_reg};
               end
               `DCTOI_OFS_STATUS: begin
                  o_prdata <= {24'h000000, status_w};
               end
               `DCTOI_OFS_INT_STAT: begin
                  o_prdata <= {27'h0, istat_reg};
               end
               `DCTOI_OFS_INT_MASK: begin
                  o_prdata <= {27'h0, mask_reg};
               end
               default: begin
                  o_prdata <= 32'h00000000;
               end
            endcase
         end else begin
            // data stands only for the pready cycle, zero otherwise
            o_prdata <= 32'h00000000;
         end
         // setting is stored only; it reaches indication logic, not the gate
         if (wr_w && i_paddr == `DCTOI_OFS_CTRL) begin
            ctrl_reg <= i_pwdata[3:0];
         end
         if (wr_w && i_paddr == `DCTOI_OFS_INT_MASK) begin
            mask_reg <= i_pwdata[`DCTOI_IRQ_W-1:0];
         end
      end
   end

endmodule

/* src/dctoi_regs.vh */
// register map, field positions, reset values and timing for the torque off interlock
`ifndef DCTOI_REGS_VH
`define DCTOI_REGS_VH

// clock and timing figures
`define DCTOI_CLK_PERIOD_NS 20
`define DCTOI_PULSE_TOL_NS 1000000
`define DCTOI_DISC_WIN_NS 200000000
// cycle counts for the figures above, sized to match the counter widths
`define DCTOI_PULSE_CYC 16'hC350
`define DCTOI_DISC_CYC 24'h989680

// byte offsets
`define DCTOI_OFS_CTRL 8'h00
`define DCTOI_OFS_CMD 8'h04
`define DCTOI_OFS_STATUS 8'h08
`define DCTOI_OFS_INT_STAT 8'h0C
`define DCTOI_OFS_INT_MASK 8'h10

// ctrl fields: indication selection for running and stopped state
`define DCTOI_CTRL_IND_RUN_LSB 0
`define DCTOI_CTRL_IND_STOP_LSB 2
`define DCTOI_CTRL_RST 4'h0

// indication codes
`define DCTOI_IND_NONE 2'h0
`define DCTOI_IND_EVENT 2'h1
`define DCTOI_IND_WARN 2'h2
`define DCTOI_IND_FAULT 2'h3

// cmd bits (write only, self clearing)
`define DCTOI_CMD_START 0
`define DCTOI_CMD_STOP 1
`define DCTOI_CMD_FAULT_RST 2

// status bits
`define DCTOI_ST_CH_A 0
`define DCTOI_ST_CH_B 1
`define DCTOI_ST_RUN 2
`define DCTOI_ST_GATE 3
`define DCTOI_ST_WARN 4
`define DCTOI_ST_IND_FLT 5
`define DCTOI_ST_A_FLT 6
`define DCTOI_ST_B_FLT 7

// interrupt status / mask bits
`define DCTOI_IRQ_LOSS 0
`define DCTOI_IRQ_RESTORE 1
`define DCTOI_IRQ_A_FLT 2
`define DCTOI_IRQ_B_FLT 3
`define DCTOI_IRQ_IND 4
`define DCTOI_IRQ_W 5
`define DCTOI_INT_MASK_RST 5'h00

`endif

/* test/dctoi_properties.sv */
// port assertions for the torque off interlock
`timescale 1ns/10ps
module dctoi_props #(
   parameter [15:0] P_PULSE_CYC = 16'h0004
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_safety_input_a,
   input wire i_safety_input_b,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire o_pready,
   input wire [31:0] o_prdata,
   input wire o_pslverr,
   input wire o_gate_enable,
   input wire o_fault,
   input wire o_channel_a_loss_fault,
   input wire o_channel_b_loss_fault
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic [15:0] low_a_reg = 16'h0000;
   logic [15:0] low_b_reg = 16'h0000;
   wire start_w = i_psel && i_pwrite && o_pready && i_paddr == 8'h04 && i_pwdata[1:0] == 2'h1;
   wire chflt_w = o_channel_a_loss_fault || o_channel_b_loss_fault;
   // low run per pin; wraps harmlessly, so no saturation logic
   always @(posedge i_clk) begin
      low_a_reg <= (i_rst || i_safety_input_a) ? 16'h0000 : low_a_reg + 16'h0001;
      low_b_reg <= (i_rst || i_safety_input_b) ? 16'h0000 : low_b_reg + 16'h0001;
   end
   property p_ready_wait; $rose(i_penable) && i_psel |-> !o_pready ##1 o_pready; endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready wait state wrong");
   property p_ready_once; o_pready |=> !o_pready; endproperty
   a_ready_once: assert property (p_ready_once) else $error("pready longer than one cycle");
   property p_err_ready; o_pslverr |-> o_pready; endproperty
   a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
   property p_rdata_idle; !o_pready |-> o_prdata == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
   property p_start_gate; $rose(o_gate_enable) |-> $past(start_w); endproperty
   a_start_gate: assert property (p_start_gate) else $error("gate on without start");
   property p_loss_a; low_a_reg > P_PULSE_CYC + 8 |-> !o_gate_enable; endproperty
   a_loss_a: assert property (p_loss_a) else $error("gate on with channel a low");
   property p_loss_b; low_b_reg > P_PULSE_CYC + 8 |-> !o_gate_enable; endproperty
   a_loss_b: assert property (p_loss_b) else $error("gate on with channel b low");
   property p_fault_gate; chflt_w |-> !o_gate_enable; endproperty
   a_fault_gate: assert property (p_fault_gate) else $error("gate on with fault");
   property p_fault_or; chflt_w |-> o_fault; endproperty
   a_fault_or: assert property (p_fault_or) else $error("channel fault not in fault");
   c_run: cover property ($rose(o_gate_enable));
   c_fault_a: cover property ($rose(o_channel_a_loss_fault));
   c_err: cover property (o_pslverr);
endmodule
bind dctoi_top dctoi_props #(.P_PULSE_CYC(P_PULSE_CYC)) u_dctoi_props (.i_clk, .i_rst,
   .i_safety_input_a, .i_safety_input_b, .i_psel, .i_penable, .i_pwrite, .i_paddr,
   .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .o_gate_enable, .o_fault,
   .o_channel_a_loss_fault, .o_channel_b_loss_fault);

/* test/dctoi_switch_model.sv */
// activation switch feeding both safety channels
`timescale 1ns/10ps
module dctoi_switch_model (
   input wire i_clk,
   input wire i_closed,
   input wire [2:0] i_lag,
   input wire i_break_a,
   input wire i_break_b,
   output logic o_in_a,
   output logic o_in_b
);
   logic [7:0] hist_reg = 8'h00;
   // switch history; lag of 7 cycles at most, far inside the skew window
   always @(posedge i_clk) begin
      hist_reg <= {hist_reg[6:0], i_closed};
   end
   // one switch drives both, b trails; a break is a one channel wiring fault
   assign o_in_a = i_closed && !i_break_a;
   assign o_in_b = (i_lag == 3'h0 ? i_closed : hist_reg[i_lag - 3'h1]) && !i_break_b;
endmodule

/* test/dual_channel_torque_off_interlock_bench.sv */
// self checking bench for the torque off interlock
`timescale 1ns/10ps
`include "dctoi_regs.vh"
module dual_channel_torque_off_interlock_bench;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   logic closed = 1'b0, brk_a = 1'b0, brk_b = 1'b0;
   logic [2:0] lag = 3'h2;
   wire in_a, in_b, pready, pslverr, gate, warn, fault, flt_a, flt_b, irq;
   wire [31:0] prdata;
   int bad_count = 0, checks = 0;
   always #10 i_clk = ~i_clk;
   dctoi_switch_model u_dctoi_switch_model (.i_clk, .i_closed(closed), .i_lag(lag),
      .i_break_a(brk_a), .i_break_b(brk_b), .o_in_a(in_a), .o_in_b(in_b));
   // short counts keep the run brief
   dctoi_top #(.P_PULSE_CYC(16'h0004), .P_DISC_CYC(24'h000028)) u_dctoi_top (.i_clk, .i_rst,
      .i_safety_input_a(in_a), .i_safety_input_b(in_b), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_prdata(prdata), .o_pslverr(pslverr), .o_gate_enable(gate), .o_warning(warn),
      .o_fault(fault), .o_channel_a_loss_fault(flt_a), .o_channel_b_loss_fault(flt_b),
      .o_irq(irq));
   // one transfer; request held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge i_clk);
      penable <= 1'b1;
      // wait for the slave; only the watchdog ends a hang
      do begin
         @(posedge i_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic cmd(input logic [31:0] v);
      apb(1'b1, `DCTOI_OFS_CMD, v);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // watchdog, about fifty times the expected run
   initial begin
      #400000;
      bad_count++;
      test_done();
   end
   initial begin
      cyc(5);
      i_rst <= 1'b0;
      apb(1'b0, `DCTOI_OFS_CTRL, 32'h0);
      chk("ctrl", 32'h0, rd);
      apb(1'b0, `DCTOI_OFS_INT_MASK, 32'h0);
      chk("mask", 32'h0, rd);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      cmd(32'h1);
      closed <= 1'b1;
      cyc(20);
      chk("no start", 32'h0, gate);
      apb(1'b1, `DCTOI_OFS_STATUS, 32'hFF);
      apb(1'b0, `DCTOI_OFS_STATUS, 32'h0);
      chk("status", 32'h3, rd);
      apb(1'b1, `DCTOI_OFS_INT_MASK, 32'h1F);
      apb(1'b1, `DCTOI_OFS_CTRL, 32'hB);
      cmd(32'h1);
      cyc(2);
      chk("run", 32'h1, gate);
      brk_a <= 1'b1;
      cyc(4);
      brk_a <= 1'b0;
      cyc(12);
      chk("pulse", 32'h1, gate);
      closed <= 1'b0;
      cyc(15);
      chk("gate off", 32'h0, gate);
      chk("run ind", 32'h1, fault);
      chk("irq", 32'h1, irq);
      apb(1'b0, `DCTOI_OFS_INT_STAT, 32'h0);
      chk("int stat", 32'h13, rd);
      cyc(2);
      chk("irq clr", 32'h0, irq);
      closed <= 1'b1;
      cyc(15);
      cmd(32'h1);
      cyc(2);
      chk("need reset", 32'h0, gate);
      cmd(32'h4);
      cmd(32'h1);
      cyc(2);
      chk("restart", 32'h1, gate);
      cmd(32'h2);
      apb(1'b1, `DCTOI_OFS_INT_MASK, 32'h0);
      closed <= 1'b0;
      cyc(15);
      chk("stop warn", 32'h1, warn);
      chk("stop flt", 32'h0, fault);
      chk("irq mask", 32'h0, irq);
      closed <= 1'b1;
      cyc(15);
      chk("warn clr", 32'h0, warn);
      apb(1'b1, `DCTOI_OFS_CTRL, 32'h0);
      // one channel broken in turn, indication off
      for (int ch = 0; ch < 2; ch++) begin
         cmd(32'h1);
         {brk_b, brk_a} <= ch ? 2'b10 : 2'b01;
         cyc(70);
         cmd(32'h4);
         chk("gate one", 32'h0, gate);
         chk("flt a", ch == 0, flt_a);
         chk("flt b", ch == 1, flt_b);
         chk("fault", 32'h1, fault);
         {brk_b, brk_a} <= 2'b00;
         cyc(15);
         cmd(32'h4);
         cyc(2);
         chk("flt reset", 32'h0, fault);
      end
      test_done();
   end
endmodule
